// ### inc/tat_pkg.sv
// Purpose: Constants shared by the tilt/accel/temp output block
// Assumes: Request word carries read/write in bit 15 and the address in bits 14:8
// Notes: Register offsets are byte addresses of 16-bit words
package tat_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [6:0] OFS_X_ACCEL = 7'h04;
   localparam logic [6:0] OFS_Y_ACCEL = 7'h06;
   localparam logic [6:0] OFS_TEMP = 7'h0a;
   localparam logic [6:0] OFS_X_TILT = 7'h0c;
   localparam logic [6:0] OFS_Y_TILT = 7'h0e;
   localparam logic [6:0] OFS_ROT = 7'h10;
   // ------------------------------------------------------------
   // Slot indices in the sample store
   // ------------------------------------------------------------
   localparam int NUM_REGS = 6;
   localparam logic [2:0] IDX_X_ACCEL = 3'h0;
   localparam logic [2:0] IDX_Y_ACCEL = 3'h1;
   localparam logic [2:0] IDX_TEMP = 3'h2;
   localparam logic [2:0] IDX_X_TILT = 3'h3;
   localparam logic [2:0] IDX_Y_TILT = 3'h4;
   localparam logic [2:0] IDX_ROT = 3'h5;
   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int DATA_W = 14;
   localparam int TEMP_W = 12;
   localparam int WORD_W = 16;
   localparam int POS_NEW_DATA = 15;
   localparam int POS_ERR_ALARM = 14;
   localparam int POS_RW = 15;
   localparam int POS_ADDR_LO = 8;
   localparam logic [15:0] DIAG_CLEAR = 16'h0000;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [11:0] TEMP_25C = 12'h4fe;
   localparam logic [4:0] BITS_PER_FRAME = 5'h10;
   localparam logic [NUM_REGS-1:0] NEW_DATA_RESET = '0;
endpackage : tat_pkg

// ### design/tat_store.sv
// Purpose: Holds the latest sample of every output register
// Assumes: All slots are written together by one sample update
// Notes: Read data come out of a register, one cycle after the request
`timescale 1ns/1ps
module tat_store
   import tat_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Sample update
   input wire logic wr_en,
   input wire logic [NUM_REGS-1:0][DATA_W-1:0] wr_data,
   // Read port
   input wire logic [2:0] rd_idx,
   output logic [DATA_W-1:0] rd_data
);
   typedef struct packed {
      logic [NUM_REGS-1:0][DATA_W-1:0] words;
      logic [DATA_W-1:0] rd;
   } tat_store_t;

   tat_store_t st_q;
   tat_store_t st_d;

   always_comb begin
      st_d = st_q;
      // Whole set written at once, so a read never mixes samples
      if (wr_en) begin
         st_d.words = wr_data;
      end
      st_d.rd = (rd_idx < 3'(NUM_REGS)) ? st_q.words[rd_idx] : '0;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_data = st_q.rd;
endmodule : tat_store

// ### design/tat_top.sv
// Purpose: Serial readout of acceleration, tilt, rotation and temperature words
// Assumes: Host is bus master in clock-idle-high mode, samples on rising sclk
// Notes: Serial pins are sampled by clk; sclk must stay well below clk/6
`timescale 1ns/1ps
module tat_top
   import tat_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial pins from host
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   // Serial data to host
   output logic dout_o,
   output logic dout_oe,
   // Sample source
   input wire logic sample_valid,
   input wire logic [DATA_W-1:0] x_accel_in,
   input wire logic [DATA_W-1:0] y_accel_in,
   input wire logic [TEMP_W-1:0] temp_in,
   input wire logic [DATA_W-1:0] x_tilt_in,
   input wire logic [DATA_W-1:0] y_tilt_in,
   input wire logic [DATA_W-1:0] rot_in,
   input wire logic [15:0] diag_status,
   // New-data flags of all registers, cleared by a read except the temperature flag
   output logic [NUM_REGS-1:0] new_data_flag
);
   typedef struct packed {
      logic [2:0] sclk_s;
      logic [2:0] cs_s;
      logic [2:0] din_s;
      logic sclk_f;
      logic cs_f;
      logic [4:0] bit_cnt;
      logic [WORD_W-1:0] rx;
      logic [WORD_W-1:0] tx;
      logic [WORD_W-1:0] next_word;
      logic arm;
      logic pend;
      logic pend_go;
      logic [2:0] pend_idx;
      logic pend_hit;
      logic [NUM_REGS-1:0] nd;
      logic dout;
      logic oe;
   } tat_state_t;

   localparam tat_state_t ST_RESET = '{
      sclk_s: 3'h7, cs_s: 3'h7, din_s: 3'h0, sclk_f: 1'b1, cs_f: 1'b1,
      bit_cnt: 5'h00, rx: WORD_RESET, tx: WORD_RESET, next_word: WORD_RESET,
      arm: 1'b0, pend: 1'b0, pend_go: 1'b0, pend_idx: 3'h0, pend_hit: 1'b0,
      nd: NEW_DATA_RESET, dout: 1'b0, oe: 1'b0};

   tat_state_t st_q;
   tat_state_t st_d;
   logic [DATA_W-1:0] rd_data;
   logic [NUM_REGS-1:0][DATA_W-1:0] wr_data;

   // ------------------------------------------------------------
   // Sample store
   // ------------------------------------------------------------
   always_comb begin
      wr_data = '0;
      wr_data[IDX_X_ACCEL] = x_accel_in;
      wr_data[IDX_Y_ACCEL] = y_accel_in;
      wr_data[IDX_TEMP] = {{(DATA_W-TEMP_W){1'b0}}, temp_in};
      wr_data[IDX_X_TILT] = x_tilt_in;
      wr_data[IDX_Y_TILT] = y_tilt_in;
      wr_data[IDX_ROT] = rot_in;
   end

   tat_store u_store (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(sample_valid),
      .wr_data(wr_data),
      .rd_idx(st_q.pend_idx),
      .rd_data(rd_data)
   );

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic logic [3:0] decode(input logic [6:0] addr);
      logic [3:0] r;
      r = 4'h0;
      unique case (addr)
         OFS_X_ACCEL: r = {1'b1, IDX_X_ACCEL};
         OFS_Y_ACCEL: r = {1'b1, IDX_Y_ACCEL};
         OFS_TEMP: r = {1'b1, IDX_TEMP};
         OFS_X_TILT: r = {1'b1, IDX_X_TILT};
         OFS_Y_TILT: r = {1'b1, IDX_Y_TILT};
         OFS_ROT: r = {1'b1, IDX_ROT};
         default: r = 4'h0;
      endcase
      return r;
   endfunction : decode

   // ------------------------------------------------------------
   // Serial engine
   // ------------------------------------------------------------
   always_comb begin
      logic sclk_rise;
      logic sclk_fall;
      logic cs_fall;
      logic cs_rise;
      logic [WORD_W-1:0] req;
      logic [3:0] dec;
      logic [NUM_REGS-1:0] nd_clr;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      cs_fall = 1'b0;
      cs_rise = 1'b0;
      req = '0;
      dec = 4'h0;
      nd_clr = '0;
      st_d = st_q;
      // Three stages; only stages two and three are compared
      st_d.sclk_s = {st_q.sclk_s[1:0], sclk};
      st_d.cs_s = {st_q.cs_s[1:0], cs_n};
      st_d.din_s = {st_q.din_s[1:0], din};
      if (st_q.sclk_s[1] == st_q.sclk_s[2]) begin
         st_d.sclk_f = st_q.sclk_s[2];
      end
      if (st_q.cs_s[1] == st_q.cs_s[2]) begin
         st_d.cs_f = st_q.cs_s[2];
      end
      sclk_rise = !st_q.sclk_f && st_d.sclk_f;
      sclk_fall = st_q.sclk_f && !st_d.sclk_f;
      cs_fall = st_q.cs_f && !st_d.cs_f;
      cs_rise = !st_q.cs_f && st_d.cs_f;

      // Frame start: present latched response, only after a read request
      if (cs_fall) begin
         st_d.bit_cnt = 5'h00;
         st_d.tx = st_q.next_word;
         st_d.oe = st_q.arm;
         st_d.dout = st_q.arm ? st_q.next_word[WORD_W-1] : 1'b0;
         st_d.arm = 1'b0;
      end else if (cs_rise) begin
         st_d.oe = 1'b0;
         st_d.dout = 1'b0;
         st_d.bit_cnt = 5'h00;
      end else if (!st_q.cs_f) begin
         if (sclk_rise && st_q.bit_cnt < BITS_PER_FRAME) begin
            req = {st_q.rx[WORD_W-2:0], st_q.din_s[2]};
            st_d.rx = req;
            st_d.bit_cnt = st_q.bit_cnt + 5'h01;
            if (st_q.bit_cnt == BITS_PER_FRAME - 5'h01) begin
               if (!req[POS_RW]) begin
                  // Read request: fetch word for the next frame
                  dec = decode(req[POS_RW-1:POS_ADDR_LO]);
                  st_d.pend = 1'b1;
                  st_d.pend_idx = dec[2:0];
                  st_d.pend_hit = dec[3];
               end
               st_d.arm = 1'b0;
            end
         end
         // First falling edge keeps MSB; later ones shift
         if (sclk_fall && st_q.bit_cnt != 5'h00 && st_q.oe) begin
            st_d.tx = {st_q.tx[WORD_W-2:0], 1'b0};
            st_d.dout = st_q.tx[WORD_W-2];
         end
      end

      // Store read data lag the index by a cycle, so take them one cycle later
      st_d.pend_go = st_q.pend && !st_q.pend_go;
      if (st_q.pend_go) begin
         st_d.pend = 1'b0;
         st_d.pend_go = 1'b0;
         st_d.arm = 1'b1;
         if (!st_q.pend_hit) begin
            st_d.next_word = WORD_RESET;
         end else if (st_q.pend_idx == IDX_TEMP) begin
            st_d.next_word = {4'h0, rd_data[TEMP_W-1:0]};
         end else begin
            // Word latched whole, later samples cannot tear it
            st_d.next_word = {st_q.nd[st_q.pend_idx],
               diag_status != DIAG_CLEAR,
               rd_data};
            nd_clr[st_q.pend_idx] = 1'b1;
         end
      end

      // Set wins over clear so an update during a read is not lost
      for (int i = 0; i < NUM_REGS; i++) begin
         if (sample_valid) begin
            st_d.nd[i] = 1'b1;
         end else if (nd_clr[i]) begin
            st_d.nd[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= ST_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign dout_o = st_q.dout;
   assign dout_oe = st_q.oe;
   assign new_data_flag = st_q.nd;
endmodule : tat_top

// ### sim/tat_top_asserts.sv
// Purpose: Port checks of the serial output block
// Assumes: One clock domain, pins seen after 3-4 cycle sync
// Notes: Bounds allow for the pin synchronisers
`timescale 1ns/1ps
module tat_top_asserts
   import tat_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic dout_o,
   input wire logic dout_oe,
   // Samples and flags
   input wire logic sample_valid,
   input wire logic [NUM_REGS-1:0] new_data_flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_cs_idle;
      cs_n [*6];
   endsequence
   sequence s_cs_held;
      !cs_n && !$past(cs_n, 2);
   endsequence
   a_oe_off_idle: assert property (s_cs_idle |-> !dout_oe)
      else $error("dout driven while deselected");
   a_dout_zero_idle: assert property (!dout_oe |-> !dout_o)
      else $error("dout not low while released");
   a_oe_rise_sel: assert property ($rose(dout_oe) |-> s_cs_held)
      else $error("dout enabled without chip select");
   a_oe_hold_frame: assert property (dout_oe && !cs_n |=> dout_oe)
      else $error("dout released inside frame");
   a_dout_shift_low: assert property ($changed(dout_o) && dout_oe && $past(dout_oe)
      |-> !sclk && !$past(sclk, 2))
      else $error("dout changed away from falling sclk");
   a_flag_set_upd: assert property (sample_valid
      |=> &{new_data_flag[5:3], new_data_flag[1:0]})
      else $error("new data flag not set by update");
   a_flag_rise_cause: assert property ($rose(new_data_flag[0]) |-> $past(sample_valid))
      else $error("new data flag rose without update");
   a_flag_clr_read: assert property ($fell(new_data_flag[0]) |-> !$past(cs_n, 3))
      else $error("new data flag cleared outside a read");
endmodule : tat_top_asserts
bind tat_top tat_top_asserts tat_top_asserts_i (.clk(clk), .rst_n(rst_n), .sclk(sclk),
   .cs_n(cs_n), .dout_o(dout_o), .dout_oe(dout_oe), .sample_valid(sample_valid),
   .new_data_flag(new_data_flag));

// ### sim/tat_host.sv
// Purpose: Host model, serial bus master
// Assumes: Clock idle high, drive on falling, sample on rising
// Notes: Released data line reads as inverse of last bit
`timescale 1ns/1ps
module tat_host (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout_o,
   input wire logic dout_oe
);
   logic last_q = 1'b0;
   logic miso;
   assign miso = dout_oe ? dout_o : ~last_q;
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b0;
   end
   // Half period of 80 ns, changes land just after clk
   task automatic half();
      repeat (20) @(posedge clk);
      #1;
   endtask : half
   // Sclk stands still between frames
   task automatic xfer(input logic [15:0] req, output logic [15:0] rsp, output logic seen);
      seen = 1'b0;
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         half();
         sclk = 1'b0;
         din = req[i];
         seen = seen | dout_oe;
         half();
         sclk = 1'b1;
         rsp[i] = miso;
         last_q = miso;
      end
      half();
      cs_n = 1'b1;
      half();
   endtask : xfer
endmodule : tat_host

// ### sim/tb.sv
// Purpose: Self-checking bench of the serial output registers
// Assumes: Host model drives the pins, bench drives samples
// Notes: Each frame after a read returns the word that read asked for; a frame after a write drives nothing
`timescale 1ns/1ps
module tb;
   import tat_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sample_valid = 1'b0;
   logic sclk, cs_n, din, dout_o, dout_oe, seen;
   logic [DATA_W-1:0] v [NUM_REGS] = '{default: 14'h0000};
   logic [15:0] diag = 16'h0000;
   logic [15:0] rsp, ex;
   logic [NUM_REGS-1:0] new_data_flag;
   logic [15:0] reqs [9] = '{16'h0400, 16'h0600, 16'h0a00, 16'h0c00, 16'h0e00, 16'h1000,
      16'h0200, 16'h0400, 16'h0000};
   int failures = 0;
   int num_checks = 0;
   always #2 clk = ~clk;
   tat_top tat_top_i (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout_o(dout_o), .dout_oe(dout_oe), .sample_valid(sample_valid), .x_accel_in(v[0]),
      .y_accel_in(v[1]), .temp_in(v[2][TEMP_W-1:0]), .x_tilt_in(v[3]), .y_tilt_in(v[4]),
      .rot_in(v[5]), .diag_status(diag), .new_data_flag(new_data_flag));
   tat_host tat_host_i (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o),
      .dout_oe(dout_oe));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic pulse();
      sample_valid = 1'b1;
      @(posedge clk);
      #1;
      sample_valid = 1'b0;
   endtask : pulse
   // Temperature word carries no flags
   function automatic logic [15:0] w(input int i, input logic nd);
      return (i == IDX_TEMP) ? {4'h0, v[i][TEMP_W-1:0]} : {nd, diag != DIAG_CLEAR, v[i]};
   endfunction : w
   task automatic wrap_up();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (4) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      chk({10'h000, new_data_flag}, 16'h0000);
      v = '{14'h3fff, 14'h1b33, 14'h04fe, 14'h31f1, 14'h0e0f, 14'h23e0};
      pulse();
      chk({10'h000, new_data_flag}, 16'h003f);
      for (int i = 0; i < 9; i++) begin
         tat_host_i.xfer(reqs[i], rsp, seen);
         ex = (i == 0) ? 16'h0000 : (i <= 6) ? w(i - 1, 1'b1) : (i == 7) ? 16'h0000 : w(0, 1'b0);
         chk(i == 0 ? {15'h0000, seen} : rsp, ex);
         // Host view: flags dropped, 14-bit field sign-extended
         if (i == 1) begin
            chk({{2{rsp[DATA_W-1]}}, rsp[DATA_W-1:0]}, 16'hffff);
         end
      end
      diag = 16'h0004;
      v[0] = 14'h0001;
      pulse();
      tat_host_i.xfer(16'h0400, rsp, seen);
      chk(rsp, 16'h0000);
      // Update lands mid-frame, after the word was taken
      fork
         tat_host_i.xfer(16'h8400, rsp, seen);
         begin
            repeat (300) @(posedge clk);
            #1;
            v[0] = 14'h2000;
            pulse();
         end
      join
      chk(rsp, 16'hc001);
      tat_host_i.xfer(16'h0400, rsp, seen);
      chk({15'h0000, seen}, 16'h0000);
      tat_host_i.xfer(16'h0000, rsp, seen);
      chk(rsp, 16'he000);
      wrap_up();
   end
endmodule : tb
